// >>> quad_wiper_params.svh
// constants for the quad wiper command decoder: offsets, codes, reset values and timing
`ifndef QUAD_WIPER_PARAMS_SVH
`define QUAD_WIPER_PARAMS_SVH

// device address byte, upper nibble
`define ADDR_PATTERN 4'h5

// instruction opcodes, upper nibble of the instruction byte
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'ha
`define OP_RD_STORED 4'hb
`define OP_WR_STORED 4'hc
`define OP_RECALL 4'hd
`define OP_SAVE 4'he
`define OP_GLOBAL_RECALL 4'h1
`define OP_GLOBAL_SAVE 4'h8
`define OP_STEP 4'h2

// fixed low fields that some instructions demand
`define SEL_ZERO 2'h0

// bit counter positions within one byte frame
`define LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`define ACK_END 4'h9

// tap range and reset values
`define TAP_MAX 6'h3f
`define TAP_MIN 6'h00
`define WIPER_RESET 6'h00
`define STORED_INIT 6'h00
`define POWERUP_SLOT 2'h0
`define LAST_CHANNEL 2'h3

// non-volatile programming time, longest allowed
`define NV_PROG_TIME_MS 5
`define CLOCK_KHZ 250000
`define NV_PROG_CYCLES (`NV_PROG_TIME_MS * `CLOCK_KHZ)

`endif

// >>> quad_wiper_pkg.sv
// types shared by the quad wiper command decoder files
package quad_wiper_pkg;

  typedef logic [5:0] tap_t;

  typedef enum logic [2:0] {
    IDLE,
    ADDR,
    INSTR,
    DATA_WR,
    DATA_RD,
    STEP,
    IGNORE
  } state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_ev_s;

  typedef struct packed {
    logic [3:0] op;
    logic [1:0] channel_sel;
    logic [1:0] slot_sel;
  } instr_s;

endpackage

// >>> stored_setting_mem.sv
// stored setting memory: one write port, one registered read port
`timescale 1ns/100ps
`default_nettype none
`include "quad_wiper_params.svh"

module stored_setting_mem #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock
  input wire logic clock_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // non-volatile contents: no reset, only a defined start value
  logic [WIDTH-1:0] mem_r [DEPTH] = '{default: WIDTH'(`STORED_INIT)};

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule
`default_nettype wire

// >>> bus_line_sampler.sv
// two-wire bus line sampler: start, stop and clock edge events
`timescale 1ns/100ps
`default_nettype none

module bus_line_sampler
  import quad_wiper_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // bus lines, synchronous to clock_in
  input wire logic scl_in,
  input wire logic sda_in,
  // events, one-cycle pulses, plus the sampled sda level
  output bus_ev_s ev_out
);

  logic scl_r;
  logic sda_r;
  bus_ev_s ev_nxt;

  // lines idle high, so reset history high to avoid a false clock rise
  assign ev_nxt.start = scl_r && scl_in && sda_r && !sda_in;
  assign ev_nxt.stop = scl_r && scl_in && !sda_r && sda_in;
  assign ev_nxt.scl_rise = !scl_r && scl_in;
  assign ev_nxt.scl_fall = scl_r && !scl_in;
  assign ev_nxt.sda = sda_in;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      ev_out <= '0;
    end else begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      ev_out <= ev_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> quad_wiper_command_decoder.sv
// quad wiper command decoder: two-wire command slave with wiper and stored settings
`timescale 1ns/100ps
`default_nettype none
`include "quad_wiper_params.svh"

module quad_wiper_command_decoder
  import quad_wiper_pkg::*;
#(
  parameter int PROG_CYCLES = `NV_PROG_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // two-wire bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_level_out,
  output logic sda_oe_out,
  // address straps, bit 3 first on the wire
  input wire logic [3:0] strap_in,
  // wiper settings and status
  output var tap_t [3:0] wiper_out,
  output logic nv_busy_out
);

  localparam int CW = $clog2(PROG_CYCLES + 1);

  bus_ev_s ev;
  state_e state_r;
  state_e next_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic ack_en_r;
  logic oe_r;
  logic step_up_r;
  instr_s instr_r;
  logic pend_r;
  logic pend_all_r;
  logic pend_host_r;
  logic [1:0] pend_ch_r;
  logic [1:0] pend_slot_r;
  tap_t pend_data_r;
  logic rcl_r;
  logic rcl_all_r;
  logic eng_on_r;
  logic eng_save_r;
  logic eng_host_r;
  logic [1:0] eng_idx_r;
  logic [1:0] eng_last_r;
  logic [1:0] eng_slot_r;
  logic rd_v_r;
  logic [1:0] rd_idx_r;
  logic [CW-1:0] prog_cnt_r;
  logic [CW-1:0] prog_cnt_nxt;
  logic busy_r;
  tap_t [3:0] wiper_r;
  tap_t [3:0] wiper_nxt;
  tap_t rd_data;

  bus_line_sampler u_sampler (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev_out(ev)
  );

  // byte framing
  wire logic rx_state = (state_r == ADDR) || (state_r == INSTR) || (state_r == DATA_WR);
  wire logic [7:0] byte_w = {shift_r[6:0], ev.sda};
  wire logic byte_done = ev.scl_rise && rx_state && (cnt_r == `LAST_BIT);
  wire logic ack_start = ev.scl_fall && rx_state && (cnt_r == `ACK_SLOT);
  wire logic ack_end = ev.scl_fall && rx_state && (cnt_r == `ACK_END);
  wire logic rd_fall = ev.scl_fall && (state_r == DATA_RD);
  wire logic step_fall = ev.scl_fall && (state_r == STEP);

  // instruction decode of the byte just completed
  wire instr_s dec_w = instr_s'(byte_w);
  wire logic sel_zero = dec_w.slot_sel == `SEL_ZERO;
  wire logic ch_zero = dec_w.channel_sel == `SEL_ZERO;
  wire logic is_rdw = (dec_w.op == `OP_RD_WIPER) && sel_zero;
  wire logic is_wrw = (dec_w.op == `OP_WR_WIPER) && sel_zero;
  wire logic is_rds = dec_w.op == `OP_RD_STORED;
  wire logic is_wrs = dec_w.op == `OP_WR_STORED;
  wire logic is_rcl = dec_w.op == `OP_RECALL;
  wire logic is_sav = dec_w.op == `OP_SAVE;
  wire logic is_grcl = (dec_w.op == `OP_GLOBAL_RECALL) && ch_zero;
  wire logic is_gsav = (dec_w.op == `OP_GLOBAL_SAVE) && ch_zero;
  wire logic is_step = (dec_w.op == `OP_STEP) && sel_zero;
  wire logic instr_ok = is_rdw || is_wrw || is_rds || is_wrs || is_rcl || is_sav || is_grcl || is_gsav || is_step;

  // address match, refused while programming
  wire logic addr_ok = (byte_w[7:4] == `ADDR_PATTERN) && (byte_w[3:0] == strap_in) && !busy_r;

  wire state_e instr_next_w = (is_rdw || is_rds) ? DATA_RD :
                              (is_wrw || is_wrs) ? DATA_WR :
                              is_step ? STEP : IGNORE;
  wire state_e byte_next_w = (state_r == ADDR) ? (addr_ok ? INSTR : IGNORE) :
                             (state_r == INSTR) ? instr_next_w : IGNORE;
  wire logic byte_ack_w = (state_r == ADDR) ? addr_ok :
                          (state_r == INSTR) ? instr_ok : 1'b1;

  // read data: the stored word is already on the registered read port by the ack end
  wire tap_t tx_tap_w = (instr_r.op == `OP_RD_STORED) ? rd_data : wiper_r[instr_r.channel_sel];
  wire logic [7:0] tx_w = {2'h0, tx_tap_w};

  wire logic wr_wiper = byte_done && (state_r == DATA_WR) && (instr_r.op == `OP_WR_WIPER);
  wire logic wr_stored = byte_done && (state_r == DATA_WR) && (instr_r.op == `OP_WR_STORED);
  wire logic stop_prog = ev.stop && pend_r;

  // byte level sequencer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= IDLE;
      next_r <= IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ack_en_r <= 1'b0;
      oe_r <= 1'b0;
      step_up_r <= 1'b0;
      instr_r <= '0;
    end else if (ev.start) begin
      state_r <= ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end else if (ev.stop) begin
      state_r <= IDLE;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end else begin
      if (ev.scl_rise && rx_state && (cnt_r < `ACK_SLOT)) begin
        shift_r <= byte_w;
        cnt_r <= cnt_r + 4'h1;
      end
      if (byte_done) begin
        next_r <= byte_next_w;
        ack_en_r <= byte_ack_w;
        if (state_r == INSTR) begin
          instr_r <= dec_w;
        end
      end
      if (ev.scl_rise && (state_r == DATA_RD) && (cnt_r < `ACK_SLOT)) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (ev.scl_rise && (state_r == STEP)) begin
        step_up_r <= ev.sda;
      end
      if (ack_start) begin
        oe_r <= ack_en_r;
        cnt_r <= `ACK_END;
      end
      if (ack_end) begin
        cnt_r <= 4'h0;
        state_r <= next_r;
        // first read bit goes out on the same falling edge that ends the ack
        oe_r <= (next_r == DATA_RD) && !tx_w[7];
        tx_r <= {tx_w[6:0], 1'b0};
      end
      if (rd_fall) begin
        if (cnt_r == `ACK_SLOT) begin
          oe_r <= 1'b0; // host owns the ack slot after the data byte
          state_r <= IGNORE;
        end else begin
          oe_r <= !tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // wiper updates: recall beats bus writes, which never overlap in practice
  always_comb begin
    wiper_nxt = wiper_r;
    if (rd_v_r) begin
      wiper_nxt[rd_idx_r] = rd_data;
    end else if (wr_wiper) begin
      wiper_nxt[instr_r.channel_sel] = byte_w[5:0];
    end else if (step_fall) begin
      if (step_up_r && (wiper_r[instr_r.channel_sel] != `TAP_MAX)) begin
        wiper_nxt[instr_r.channel_sel] = wiper_r[instr_r.channel_sel] + 6'h01;
      end else if (!step_up_r && (wiper_r[instr_r.channel_sel] != `TAP_MIN)) begin
        wiper_nxt[instr_r.channel_sel] = wiper_r[instr_r.channel_sel] - 6'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wiper_r <= {4{`WIPER_RESET}};
    end else begin
      wiper_r <= wiper_nxt;
    end
  end

  // stored writes wait here until stop
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pend_r <= 1'b0;
      pend_all_r <= 1'b0;
      pend_host_r <= 1'b0;
      pend_ch_r <= 2'h0;
      pend_slot_r <= 2'h0;
      pend_data_r <= `STORED_INIT;
    end else if (ev.stop) begin
      pend_r <= 1'b0;
    end else if (byte_done && (state_r == INSTR) && (is_sav || is_gsav)) begin
      pend_r <= 1'b1;
      pend_all_r <= is_gsav;
      pend_host_r <= 1'b0;
      pend_ch_r <= dec_w.channel_sel;
      pend_slot_r <= dec_w.slot_sel;
    end else if (wr_stored) begin
      pend_r <= 1'b1;
      pend_all_r <= 1'b0;
      pend_host_r <= 1'b1;
      pend_ch_r <= instr_r.channel_sel;
      pend_slot_r <= instr_r.slot_sel;
      pend_data_r <= byte_w[5:0];
    end
  end

  // recall waits for the end of the instruction acknowledge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rcl_r <= 1'b0;
      rcl_all_r <= 1'b0;
    end else if (ev.start || ev.stop || ack_end) begin
      rcl_r <= 1'b0;
    end else if (byte_done && (state_r == INSTR) && (is_rcl || is_grcl)) begin
      rcl_r <= 1'b1;
      rcl_all_r <= is_grcl;
    end
  end

  // copy engine: walks one or all channels, one per cycle; reset runs a power-up recall of slot 0
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      eng_on_r <= 1'b1;
      eng_save_r <= 1'b0;
      eng_host_r <= 1'b0;
      eng_idx_r <= 2'h0;
      eng_last_r <= `LAST_CHANNEL;
      eng_slot_r <= `POWERUP_SLOT;
    end else if (eng_on_r) begin
      eng_on_r <= eng_idx_r != eng_last_r;
      eng_idx_r <= eng_idx_r + 2'h1;
    end else if (stop_prog) begin
      eng_on_r <= 1'b1;
      eng_save_r <= 1'b1;
      eng_host_r <= pend_host_r;
      eng_idx_r <= pend_all_r ? 2'h0 : pend_ch_r;
      eng_last_r <= pend_all_r ? `LAST_CHANNEL : pend_ch_r;
      eng_slot_r <= pend_slot_r;
    end else if (ack_end && rcl_r) begin
      eng_on_r <= 1'b1;
      eng_save_r <= 1'b0;
      eng_host_r <= 1'b0;
      eng_idx_r <= rcl_all_r ? 2'h0 : instr_r.channel_sel;
      eng_last_r <= rcl_all_r ? `LAST_CHANNEL : instr_r.channel_sel;
      eng_slot_r <= instr_r.slot_sel;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_v_r <= 1'b0;
      rd_idx_r <= 2'h0;
    end else begin
      rd_v_r <= eng_on_r && !eng_save_r;
      rd_idx_r <= eng_idx_r;
    end
  end

  wire logic mem_we = eng_on_r && eng_save_r;
  wire tap_t mem_wdata = eng_host_r ? pend_data_r : wiper_r[eng_idx_r];
  wire logic [3:0] mem_waddr = {eng_idx_r, eng_slot_r};
  wire logic [3:0] mem_raddr = (eng_on_r && !eng_save_r) ? {eng_idx_r, eng_slot_r} :
                                                            {instr_r.channel_sel, instr_r.slot_sel};

  stored_setting_mem #(
    .WIDTH(6),
    .DEPTH(16),
    .AW(4)
  ) u_mem (
    .clock_in(clock_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_waddr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(mem_raddr),
    .rd_data_out(rd_data)
  );

  // programming time: the words land at once, busy covers the cell's worst case
  assign prog_cnt_nxt = stop_prog ? CW'(PROG_CYCLES) :
                        (prog_cnt_r != '0) ? prog_cnt_r - CW'(1) : '0;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prog_cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      prog_cnt_r <= prog_cnt_nxt;
      busy_r <= prog_cnt_nxt != '0;
    end
  end

  // open drain: only ever pulls low
  assign sda_level_out = 1'b0;
  assign sda_oe_out = oe_r;
  assign wiper_out = wiper_r;
  assign nv_busy_out = busy_r;

endmodule
`default_nettype wire

// >>> quad_wiper_sva.sv
// port-level assertion checker for the quad wiper command decoder
`timescale 1ns/100ps
`default_nettype none
module qw_sva
  import quad_wiper_pkg::*;
#(
  parameter int PROG_CYCLES = 400
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_level_out,
  input wire logic sda_oe_out,
  input wire logic [3:0] strap_in,
  // settings and status
  input wire tap_t [3:0] wiper_out,
  input wire logic nv_busy_out
);
  logic scl_r;
  logic sda_r;
  logic [3:0] fall_r;
  logic [3:0] edge_r;
  logic [5:0] stop_r;
  int cnt_r;
  wire fall_w = scl_r & ~scl_in;
  wire stop_w = scl_r & scl_in & ~sda_r & sda_in;
  wire start_w = scl_r & scl_in & sda_r & ~sda_in;
  // short histories allow for the sampler's two-cycle latency
  always_ff @(posedge clock_in) begin
    scl_r <= scl_in;
    sda_r <= sda_in;
    fall_r <= {fall_r[2:0], fall_w};
    edge_r <= {edge_r[2:0], fall_w | stop_w | start_w};
    stop_r <= {stop_r[4:0], stop_w};
    cnt_r <= nv_busy_out ? cnt_r + 1 : 0;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_busy_on;
    $rose(nv_busy_out);
  endsequence
  sequence s_busy_hold;
    nv_busy_out [*8];
  endsequence
  property p_open_drain;
    sda_level_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda level not low");
  property p_ack_on_fall;
    $rose(sda_oe_out) |-> |fall_r;
  endproperty
  a_ack_on_fall: assert property (p_ack_on_fall) else $error("sda driven without scl fall");
  property p_oe_scl_low;
    $rose(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda pulled while scl high");
  property p_oe_release;
    $fell(sda_oe_out) |-> |edge_r;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("sda released off an edge");
  property p_busy_after_stop;
    s_busy_on |-> |stop_r;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("programming without stop");
  property p_busy_min;
    s_busy_on |-> s_busy_hold;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("programming too short");
  property p_busy_max;
    cnt_r <= PROG_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("programming too long");
  property p_busy_nack;
    nv_busy_out |-> !$rose(sda_oe_out);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while programming");
  property p_reset_state;
    $fell(rst_in) |-> wiper_out == '0 && !nv_busy_out && !sda_oe_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule
`default_nettype wire

// >>> host_bus_model.sv
// host bus master model for the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  // clock
  input wire logic clock_in,
  // bus
  input wire logic dev_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv = 1'b1;
  initial scl_out = 1'b1;
  // pull-up: a released line reads high
  assign sda_out = drv & ~dev_oe_in;
  task automatic hold(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // also serves as repeated start from a low clock
  task automatic start_c;
    drv = 1'b1;
    hold(4);
    scl_out = 1'b1;
    hold(8);
    drv = 1'b0;
    hold(8);
    scl_out = 1'b0;
    hold(4);
  endtask
  // one bit; the level at the rise sets a step direction
  task automatic bitx(input logic b, output logic r);
    drv = b;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    r = sda_out;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask
  // msb first, then the acknowledge slot left released
  task automatic bytex(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(1'b1, a);
    ack = ~a;
  endtask
  task automatic stop_c;
    drv = 1'b0;
    hold(4);
    scl_out = 1'b1;
    hold(8);
    drv = 1'b1;
    hold(12);
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking testbench for the quad wiper command decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] strap = 4'h0;
  wire scl;
  wire sda;
  wire oe;
  wire lvl;
  wire busy;
  wire [3:0][5:0] wip;
  int err_count = 0;
  int total_checks = 0;
  logic [5:0] w_m [4] = '{default: 6'h00};
  logic [5:0] s_m [4][4] = '{default: '{default: 6'h00}};
  logic [7:0] rd;
  logic [7:0] x;
  logic [2:0] ak;
  logic [1:0] c;
  logic [5:0] v;
  logic [15:0] p;
  logic a;
  always #2 clock_in = ~clock_in;
  host_bus_model host (.clock_in(clock_in), .dev_oe_in(oe), .scl_out(scl), .sda_out(sda));
  quad_wiper_command_decoder #(.PROG_CYCLES(400)) DUT (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda), .sda_level_out(lvl), .sda_oe_out(oe), .strap_in(strap), .wiper_out(wip), .nv_busy_out(busy));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [3:0] sa, input logic [7:0] ins, input logic [7:0] d, input int n);
    host.start_c();
    host.bytex({4'h5, sa}, x, ak[2]);
    host.bytex(ins, x, ak[1]);
    if (n > 2)
      host.bytex(d, rd, ak[0]);
    host.stop_c();
  endtask
  task automatic ww(input logic [1:0] ch, input logic [5:0] val);
    xfer(strap, {4'ha, ch, 2'h0}, {2'h3, val}, 3);
    w_m[ch] = val;
    check("wr ack", {5'h0, ak}, 8'h07);
  endtask
  task automatic chk_w;
    for (int i = 0; i < 4; i++)
      check("wiper", {2'h0, wip[i]}, {2'h0, w_m[i]});
  endtask
  // addresses the device once while programming runs, expecting a nack, then waits for busy to drop
  task automatic wait_nv;
    int k = 0;
    check("busy", {7'h0, busy}, 8'h01);
    host.start_c();
    host.bytex({4'h5, strap}, x, a);
    host.stop_c();
    check("busy nack", {7'h0, a}, 8'h00);
    while (busy === 1'b1 && k < 500) begin
      host.hold(1);
      k++;
    end
    check("busy end", {7'h0, busy}, 8'h00);
  endtask
  function automatic logic [5:0] step(input logic [5:0] w, input logic up);
    if (up)
      return (w == 6'h3f) ? w : w + 6'h01;
    return (w == 6'h00) ? w : w - 6'h01;
  endfunction
  initial begin
    #160000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    a = 1'($urandom(32'he5cd0325));
    strap = 4'($urandom());
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    host.hold(10);
    chk_w();
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 6'h3f : 6'($urandom());
      ww(2'(i), v);
      xfer(strap, {4'h9, 2'(i), 2'h0}, 8'hff, 3);
      check("rd wiper", rd, {2'h0, v});
    end
    chk_w();
    $display("wiper test done");
    for (int i = 0; i < 4; i++) begin
      c = 2'($urandom_range(3));
      v = 6'($urandom());
      xfer(strap, {4'hc, c, 2'(i)}, {2'h2, v}, 3);
      s_m[c][i] = v;
      check("st ack", {5'h0, ak}, 8'h07);
      wait_nv();
      xfer(strap, {4'hb, c, 2'(i)}, 8'hff, 3);
      check("rd stored", rd, {2'h0, v});
    end
    $display("stored test done");
    c = 2'($urandom_range(3));
    xfer(strap, {4'he, c, 2'h3}, 8'h00, 2);
    check("save ack", {6'h0, ak[2:1]}, 8'h03);
    s_m[c][3] = w_m[c];
    wait_nv();
    ww(c, ~w_m[c]);
    xfer(strap, {4'hd, c, 2'h3}, 8'h00, 2);
    check("recall ack", {6'h0, ak[2:1]}, 8'h03);
    w_m[c] = s_m[c][3];
    chk_w();
    xfer(strap, {4'h8, 2'h0, 2'h2}, 8'h00, 2);
    check("gsave ack", {6'h0, ak[2:1]}, 8'h03);
    for (int i = 0; i < 4; i++)
      s_m[i][2] = w_m[i];
    wait_nv();
    ww(2'h0, ~w_m[0]);
    ww(2'h3, 6'h15);
    xfer(strap, {4'h1, 2'h0, 2'h2}, 8'h00, 2);
    check("grecall ack", {6'h0, ak[2:1]}, 8'h03);
    for (int i = 0; i < 4; i++)
      w_m[i] = s_m[i][2];
    chk_w();
    $display("copy test done");
    for (int r = 0; r < 3; r++) begin
      v = (r == 0) ? 6'h3e : (r == 1) ? 6'h01 : 6'($urandom());
      p = (r == 0) ? 16'h0007 : (r == 1) ? 16'hfff8 : 16'($urandom());
      ww(2'(r), v);
      host.start_c();
      host.bytex({4'h5, strap}, x, a);
      host.bytex({4'h2, 2'(r), 2'h0}, x, a);
      check("step ack", {7'h0, a}, 8'h01);
      for (int i = 0; i < 16; i++) begin
        host.bitx(p[i], a);
        w_m[r] = step(w_m[r], p[i]);
      end
      host.stop_c();
      chk_w();
    end
    $display("step test done");
    xfer(~strap, {4'ha, 2'h0, 2'h0}, 8'h15, 3);
    check("strap nack", {7'h0, ak[2]}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      xfer(strap, {(i == 0) ? 4'h9 : (i == 1) ? 4'ha : 4'h2, 2'h1, 2'h1}, 8'h15, 3);
      check("bad instr", {6'h0, ak[2:1]}, 8'h02);
    end
    chk_w();
    $display("refusal test done");
    // second reset: stored slot 0 survives and is recalled into every wiper
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    host.hold(10);
    for (int i = 0; i < 4; i++)
      w_m[i] = s_m[i][0];
    chk_w();
    $display("power-up recall test done");
    tally_and_finish();
  end
endmodule
bind quad_wiper_command_decoder qw_sva #(.PROG_CYCLES(PROG_CYCLES)) chk (.clock_in(clock_in), .rst_in(rst_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_level_out(sda_level_out), .sda_oe_out(sda_oe_out),
  .strap_in(strap_in), .wiper_out(wiper_out), .nv_busy_out(nv_busy_out));
`default_nettype wire
